/* File: inc/hbp_pkg.sv */
// shared constants, state type and byte lane helpers for the host bus port
package hbp_pkg;

  // ***************************************************************
  // widths
  // ***************************************************************
  localparam int DATA_W = 32;
  localparam int LANES = 4;
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 1;
  localparam int DEC_LO = 4;
  localparam int DEC_W = ADDR_HI - DEC_LO + 1;
  // lclk, mode, ads, cycle, dir, rd, wr, io, be[4], addr[15], data[32]
  localparam int SYNC_W = 8 + LANES + (ADDR_HI - ADDR_LO + 1) + DATA_W;

  // ***************************************************************
  // active-low byte enable patterns
  // ***************************************************************
  localparam logic [3:0] BE_NONE = 4'hF;
  localparam logic [3:0] BE_DWORD = 4'h0;
  localparam logic [3:0] BE_LOW = 4'hC;
  localparam logic [3:0] BE_HIGH = 4'h3;
  localparam logic [3:0] BE_B0 = 4'hE;
  localparam logic [3:0] BE_B1 = 4'hD;
  localparam logic [3:0] BE_B2 = 4'hB;
  localparam logic [3:0] BE_B3 = 4'h7;
  localparam logic [1:0] BE_ISA_OFF = 2'h3;
  localparam logic [3:0] LANES_OFF = 4'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // ***************************************************************
  // access sequencer states
  // ***************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_RD_WAIT, ST_RD_HOLD, ST_WR_STROBE, ST_WR_WAIT,
    ST_LB_WAIT, ST_LB_DONE, ST_LB_READY
  } hbp_state_t;

  // legal lane patterns; isa mode sees only the lower two enables
  function automatic logic hbp_be_legal(input logic [3:0] be_n, input logic isa);
    logic ok;
    ok = 1'b0;
    if (isa) begin
      ok = (be_n[1:0] != BE_ISA_OFF);
    end else begin
      case (be_n)
        BE_DWORD, BE_LOW, BE_HIGH, BE_B0, BE_B1, BE_B2, BE_B3: ok = 1'b1;
        default: ok = 1'b0;
      endcase
    end
    return ok;
  endfunction

endpackage

/* File: rtl/hbp_sync.sv */
// three-stage input synchroniser that accepts a bit once stages two and three agree
`timescale 1ns/1ps
module hbp_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } hbp_sync_st_t;

  hbp_sync_st_t q;
  hbp_sync_st_t d;

  // s1 only feeds s2; the agreement filter looks at s2 and s3
  always_comb begin
    d = q;
    d.s1 = din;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.stable = (q.s2 & ~(q.s2 ^ q.s3)) | (q.stable & (q.s2 ^ q.s3));
  end

  // reset to idle pin levels so no strobe looks active
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      q <= d;
    end
  end

  assign dout = q.stable;
endmodule

/* File: rtl/hbp_top.sv */
// host bus slave port: isa-style async strobes and 32-bit local bus, one sequencer
// Operation
// - isa mode is a sixteen-bit slave, at most two bytes on the low half.
// - address bits one to fifteen select io space and the register.
// - decodes count only while the io qualifier is low.
// - isa reads strobed by active-low read; address valid first, data returned.
// - ready drops at the strobe's leading edge when the access cannot finish.
// - ready rises on the first clock edge after the internal access is done.
// - isa byte lanes chosen by the two lower active-low byte enables.
// - both enables use both lanes; one uses one; unused lane floats or ignored.
// - claim output active while bits fifteen to four match and qualifier low.
// - local bus direction sampled on first bus clock rise with cycle active.
// - local bus address and enables transparent while strobe low, latched on rise.
`timescale 1ns/1ps
module hbp_top
  import hbp_pkg::*;
#(
  parameter logic [hbp_pkg::DEC_W-1:0] DECODE_BASE = 12'h030
) (
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic LOCAL_BUS_MODE_SELECT_N,
  input wire logic BUS_CLK,
  input wire logic [hbp_pkg::ADDR_HI:hbp_pkg::ADDR_LO] HOST_ADDR,
  input wire logic IO_SPACE_QUALIFIER,
  input wire logic ASYNC_READ_STROBE_N,
  input wire logic ASYNC_WRITE_STROBE_N,
  input wire logic [hbp_pkg::LANES-1:0] BYTE_LANE_ENABLE_N,
  input wire logic ADDRESS_LATCH_STROBE_N,
  input wire logic CYCLE_QUALIFIER_N,
  input wire logic ACCESS_DIRECTION,
  input wire logic [hbp_pkg::DATA_W-1:0] DATA_IN,
  output logic [hbp_pkg::DATA_W-1:0] DATA_OUT,
  output logic [hbp_pkg::LANES-1:0] DATA_OE,
  output logic ASYNC_READY_OUT,
  output logic SYNC_READY_N,
  output logic LOCAL_DEVICE_CLAIM_N,
  output logic ACC_REQ,
  output logic ACC_WRITE,
  output logic [hbp_pkg::ADDR_HI:hbp_pkg::ADDR_LO] ACC_ADDR,
  output logic [hbp_pkg::LANES-1:0] ACC_BE,
  output logic [hbp_pkg::DATA_W-1:0] ACC_WDATA,
  input wire logic ACC_DONE,
  input wire logic [hbp_pkg::DATA_W-1:0] ACC_RDATA
);
  import hbp_pkg::*;

  // ***************************************************************
  // pin synchronisation
  // ***************************************************************
  localparam logic [SYNC_W-1:0] SYNC_IDLE = {1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1,
                                             BE_NONE, {(ADDR_HI-ADDR_LO+1){1'b0}}, DATA_ZERO};

  logic [SYNC_W-1:0] sv;
  logic s_lclk, s_mode_n, s_ads_n, s_cyc_n, s_dir, s_rd_n, s_wr_n, s_io;
  logic [LANES-1:0] s_be_n;
  logic [ADDR_HI:ADDR_LO] s_addr;
  logic [DATA_W-1:0] s_data;

  // one synchroniser for every pin; data skew is filtered per bit
  hbp_sync #(.W(SYNC_W), .RST_VAL(SYNC_IDLE)) u_sync (
    .clk(MCLK),
    .rst(SYS_RST),
    .din({BUS_CLK, LOCAL_BUS_MODE_SELECT_N, ADDRESS_LATCH_STROBE_N, CYCLE_QUALIFIER_N,
          ACCESS_DIRECTION, ASYNC_READ_STROBE_N, ASYNC_WRITE_STROBE_N, IO_SPACE_QUALIFIER,
          BYTE_LANE_ENABLE_N, HOST_ADDR, DATA_IN}),
    .dout(sv)
  );

  assign {s_lclk, s_mode_n, s_ads_n, s_cyc_n, s_dir, s_rd_n, s_wr_n, s_io, s_be_n, s_addr, s_data} = sv;

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    hbp_state_t st;
    logic lclk;
    logic [ADDR_HI:ADDR_LO] lat_addr;
    logic lat_io;
    logic [LANES-1:0] lat_be_n;
    logic [DATA_W-1:0] dout;
    logic [LANES-1:0] oe;
    logic async_ready_out;
    logic srdy_n;
    logic claim_n;
    logic req;
    logic wr;
    logic [ADDR_HI:ADDR_LO] addr;
    logic [LANES-1:0] be;
    logic [DATA_W-1:0] wdata;
  } hbp_top_st_t;

  hbp_top_st_t q;
  hbp_top_st_t d;

  logic isa, lclk_rise, hit, be_ok;
  logic [ADDR_HI:ADDR_LO] dec_addr;
  logic [LANES-1:0] dec_be_n;
  logic dec_io;

  // ***************************************************************
  // decode and sequencer
  // ***************************************************************
  // mode pin high selects isa attachment; local bus grounds it
  always_comb begin
    isa = s_mode_n;
    lclk_rise = s_lclk & ~q.lclk;
    // latch is transparent while the address strobe is low
    dec_addr = isa ? s_addr : (s_ads_n ? q.lat_addr : s_addr);
    dec_io = isa ? s_io : (s_ads_n ? q.lat_io : s_io);
    dec_be_n = isa ? {BE_ISA_OFF, s_be_n[1:0]} : (s_ads_n ? q.lat_be_n : s_be_n);
    hit = !dec_io && (dec_addr[ADDR_HI:DEC_LO] == DECODE_BASE);
    be_ok = hbp_be_legal(dec_be_n, isa);
    d = q;
    d.lclk = s_lclk;
    d.req = 1'b0;
    d.claim_n = !hit;
    if (!s_ads_n) begin
      d.lat_addr = s_addr;
      d.lat_io = s_io;
      d.lat_be_n = s_be_n;
    end
    case (q.st)
      ST_IDLE: begin
        if (isa && hit && be_ok && !s_rd_n) begin
          // a read always waits on the internal side, so stretch at once
          d.async_ready_out = 1'b0;
          d.req = 1'b1;
          d.wr = 1'b0;
          d.addr = dec_addr;
          d.be = ~dec_be_n;
          d.st = ST_RD_WAIT;
        end else if (isa && hit && be_ok && !s_wr_n) begin
          d.addr = dec_addr;
          d.be = ~dec_be_n;
          d.st = ST_WR_STROBE;
        end else if (!isa && lclk_rise && !s_cyc_n && hit && be_ok) begin
          d.wr = s_dir;
          d.wdata = s_data;
          d.addr = dec_addr;
          d.be = ~dec_be_n;
          d.req = 1'b1;
          d.st = ST_LB_WAIT;
        end
      end
      ST_RD_WAIT: begin
        if (ACC_DONE) begin
          d.dout = ACC_RDATA;
          d.oe = q.be;
          d.async_ready_out = 1'b1;
          d.st = ST_RD_HOLD;
        end
      end
      ST_RD_HOLD: begin
        if (s_rd_n) begin
          d.oe = LANES_OFF;
          d.st = ST_IDLE;
        end
      end
      ST_WR_STROBE: begin
        // data tracks the pins while the strobe is low, so the trailing edge keeps the last value;
        // sampling after the strobe rises would lose the host's data hold time
        if (!s_wr_n) begin
          d.wdata = s_data;
        end else begin
          d.wr = 1'b1;
          d.req = 1'b1;
          d.st = ST_WR_WAIT;
        end
      end
      ST_WR_WAIT: begin
        // a new strobe while the write drains must wait
        if (!s_rd_n || !s_wr_n) begin
          d.async_ready_out = 1'b0;
        end
        if (ACC_DONE) begin
          d.async_ready_out = 1'b1;
          d.st = ST_IDLE;
        end
      end
      ST_LB_WAIT: begin
        if (ACC_DONE) begin
          if (!q.wr) begin
            d.dout = ACC_RDATA;
            d.oe = q.be;
          end
          d.st = ST_LB_DONE;
        end
      end
      ST_LB_DONE: begin
        if (lclk_rise) begin
          d.srdy_n = 1'b0;
          d.st = ST_LB_READY;
        end
      end
      ST_LB_READY: begin
        // ready held one bus clock, then the lanes are released
        if (lclk_rise) begin
          d.srdy_n = 1'b1;
          d.oe = LANES_OFF;
          d.st = ST_IDLE;
        end
      end
      default: begin
        d.st = ST_IDLE;
      end
    endcase
  end

  // synchronous reset to an idle, released bus
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      q <= '{st: ST_IDLE, lclk: 1'b0, lat_addr: '0, lat_io: 1'b1, lat_be_n: BE_NONE,
             dout: DATA_ZERO, oe: LANES_OFF, async_ready_out: 1'b1, srdy_n: 1'b1, claim_n: 1'b1,
             req: 1'b0, wr: 1'b0, addr: '0, be: LANES_OFF, wdata: DATA_ZERO};
    end else begin
      q <= d;
    end
  end

  // ***************************************************************
  // outputs, all straight from flops
  // ***************************************************************
  assign DATA_OUT = q.dout;
  assign DATA_OE = q.oe;
  assign ASYNC_READY_OUT = q.async_ready_out;
  assign SYNC_READY_N = q.srdy_n;
  assign LOCAL_DEVICE_CLAIM_N = q.claim_n;
  assign ACC_REQ = q.req;
  assign ACC_WRITE = q.wr;
  assign ACC_ADDR = q.addr;
  assign ACC_BE = q.be;
  assign ACC_WDATA = q.wdata;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_isa_upper_float: assert property (s_mode_n && $past(s_mode_n) |-> DATA_OE[3:2] == 2'h0)
    else $error("upper lanes driven in isa mode");
  a_claim_match: assert property (!LOCAL_DEVICE_CLAIM_N |-> $past(hit))
    else $error("claim without address match");
  a_req_qualified: assert property (ACC_REQ && !ACC_WRITE |-> $past(hit) || $past(q.st) == ST_WR_STROBE)
    else $error("request without valid decode");
  a_read_stretch: assert property (ACC_REQ && !ACC_WRITE && q.st == ST_RD_WAIT |-> !ASYNC_READY_OUT)
    else $error("ready not dropped on isa read");
  a_ready_return: assert property (q.st == ST_RD_WAIT && ACC_DONE |=> ASYNC_READY_OUT && DATA_OE == ACC_BE)
    else $error("ready not restored after done");
  a_lane_match: assert property (DATA_OE != LANES_OFF |-> DATA_OE == ACC_BE)
    else $error("driven lanes differ from enables");
  a_dir_sample: assert property (ACC_REQ && $past(q.st) == ST_IDLE && !$past(isa) |-> ACC_WRITE == $past(s_dir))
    else $error("direction not sampled at cycle start");
  a_lb_be_legal: assert property (ACC_REQ && !$past(isa) |-> hbp_be_legal(~ACC_BE, 1'b0))
    else $error("illegal local bus lane pattern");
  a_addr_latch: assert property (s_ads_n && $past(s_ads_n) |-> q.lat_addr == $past(q.lat_addr))
    else $error("address latch moved while closed");
  a_isa_read_addr: assert property (ACC_REQ && !ACC_WRITE && q.st == ST_RD_WAIT |-> ACC_ADDR == $past(s_addr))
    else $error("isa read address not from pins");

  c_isa_read: cover property (q.st == ST_RD_WAIT ##[1:50] q.st == ST_RD_HOLD);
  c_isa_write: cover property (q.st == ST_WR_STROBE ##[1:50] q.st == ST_WR_WAIT);
  c_lb_access: cover property (q.st == ST_LB_WAIT ##[1:100] !SYNC_READY_N);
  c_write_stretch: cover property (q.st == ST_WR_WAIT && !ASYNC_READY_OUT);
endmodule

/* File: bench/hbp_host_model.sv */
// host bus master model: isa strobed cycles and local bus cycles
`timescale 1ns/1ps
module hbp_host_model
  import hbp_pkg::*;
(
  input wire logic MCLK,
  output logic BUS_CLK,
  output logic [hbp_pkg::ADDR_HI:hbp_pkg::ADDR_LO] HOST_ADDR,
  output logic IO_SPACE_QUALIFIER,
  output logic ASYNC_READ_STROBE_N,
  output logic ASYNC_WRITE_STROBE_N,
  output logic [hbp_pkg::LANES-1:0] BYTE_LANE_ENABLE_N,
  output logic ADDRESS_LATCH_STROBE_N,
  output logic CYCLE_QUALIFIER_N,
  output logic ACCESS_DIRECTION,
  output logic [hbp_pkg::DATA_W-1:0] DATA_IN,
  input wire logic [hbp_pkg::DATA_W-1:0] DATA_OUT,
  input wire logic [hbp_pkg::LANES-1:0] DATA_OE,
  input wire logic ASYNC_READY_OUT,
  input wire logic SYNC_READY_N,
  input wire logic LOCAL_DEVICE_CLAIM_N
);
  // ***************************************************************
  // idle pins and free running bus clock
  // ***************************************************************
  initial begin
    {BUS_CLK, HOST_ADDR, ACCESS_DIRECTION, DATA_IN} = '0;
    {IO_SPACE_QUALIFIER, ASYNC_READ_STROBE_N, ASYNC_WRITE_STROBE_N} = 3'h7;
    {BYTE_LANE_ENABLE_N, ADDRESS_LATCH_STROBE_N, CYCLE_QUALIFIER_N} = 6'h3F;
  end
  always #40 BUS_CLK = ~BUS_CLK;

  // isa cycle: address first, strobe held until ready is seen back high, a write strobe at most eleven clocks
  task automatic isa(input logic wr, input logic io, input logic [15:1] a, input logic [1:0] be,
      input logic [31:0] d, output logic low, output logic cl, output logic [31:0] q, output logic [3:0] oe);
    HOST_ADDR <= a;
    IO_SPACE_QUALIFIER <= io;
    BYTE_LANE_ENABLE_N <= {2'h3, be};
    DATA_IN <= d;
    @(posedge MCLK);
    ASYNC_READ_STROBE_N <= wr;
    ASYNC_WRITE_STROBE_N <= !wr;
    low = 1'b0;
    cl = 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge MCLK);
      low = low | (ASYNC_READY_OUT === 1'b0);
      if (n == 6) cl = LOCAL_DEVICE_CLAIM_N;
      if ((low && ASYNC_READY_OUT === 1'b1) || (wr && n == 10)) break;
    end
    q = DATA_OUT;
    oe = DATA_OE;
    {ASYNC_READ_STROBE_N, ASYNC_WRITE_STROBE_N, IO_SPACE_QUALIFIER} <= 3'h7;
    DATA_IN <= ~d; // released lines never keep the old value
    repeat (12) @(posedge MCLK);
  endtask

  // local bus cycle: strobe low over one bus clock rise, wait for ready
  task automatic lb(input logic wr, input logic [15:1] a, input logic [3:0] be, input logic [31:0] d,
      output logic [31:0] q, output logic [3:0] oe, output logic to);
    for (int n = 0; n < 40 && BUS_CLK !== 1'b0; n++) @(posedge MCLK);
    {HOST_ADDR, BYTE_LANE_ENABLE_N, DATA_IN} <= {a, be, d};
    ACCESS_DIRECTION <= wr;
    {IO_SPACE_QUALIFIER, ADDRESS_LATCH_STROBE_N} <= 2'h0;
    for (int n = 0; n < 40 && BUS_CLK !== 1'b1; n++) @(posedge MCLK);
    @(posedge MCLK);
    // cycle qualifier goes low as the strobe rises and the pins change, so only the latched copy can be used
    ADDRESS_LATCH_STROBE_N <= 1'b1;
    CYCLE_QUALIFIER_N <= 1'b0;
    {HOST_ADDR, BYTE_LANE_ENABLE_N} <= {~a, ~be};
    to = 1'b1;
    for (int n = 0; n < 300 && to; n++) begin
      @(posedge MCLK);
      to = (SYNC_READY_N !== 1'b0);
    end
    q = DATA_OUT;
    oe = DATA_OE;
    for (int n = 0; n < 40 && SYNC_READY_N === 1'b0; n++) @(posedge MCLK);
    to = to | (SYNC_READY_N === 1'b0); // ready stuck low counts as a timeout
    {CYCLE_QUALIFIER_N, IO_SPACE_QUALIFIER} <= 2'h3;
    DATA_IN <= ~d;
    repeat (40) @(posedge MCLK);
  endtask
endmodule

/* File: bench/host_bus_slave_port_tb.sv */
// self-checking bench for the host bus slave port
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("wrong value %s expected %h seen %h", nm, e, a); end end
module host_bus_slave_port_tb;
  import hbp_pkg::*;
  typedef struct packed {logic wr; logic io; logic [14:0] a; logic [1:0] be; logic low; logic cl;
    logic [3:0] ln; logic req;} hbp_row_t;
  localparam logic [14:0] HIT = {12'h030, 3'h2};
  localparam logic [31:0] RD_PAT = 32'hC35A_96E1;
  localparam logic [31:0] WR_PAT = 32'h1E87_2B4D;
  // ***************************************************************
  // isa cases: request, ready drop, claim and lanes per row
  // ***************************************************************
  localparam hbp_row_t ROWS [8] = '{'{0, 0, HIT, 2'h0, 1, 0, 4'h3, 1}, '{0, 0, HIT, 2'h2, 1, 0, 4'h1, 1},
    '{0, 0, HIT, 2'h1, 1, 0, 4'h2, 1}, '{0, 0, HIT + 15'h10, 2'h0, 0, 1, 4'h0, 0},
    '{0, 1, HIT, 2'h0, 0, 1, 4'h0, 0}, '{0, 0, HIT, 2'h3, 0, 0, 4'h0, 0},
    '{1, 0, HIT, 2'h0, 0, 0, 4'h3, 1}, '{1, 0, HIT, 2'h2, 0, 0, 4'h1, 1}};
  localparam logic [3:0] LB_BE [7] = '{BE_DWORD, BE_LOW, BE_HIGH, BE_B0, BE_B1, BE_B2, BE_B3};
  logic MCLK = 0, SYS_RST = 1, LOCAL_BUS_MODE_SELECT_N = 1, ACC_DONE = 0;
  logic BUS_CLK, IO_SPACE_QUALIFIER, ASYNC_READ_STROBE_N, ASYNC_WRITE_STROBE_N, ADDRESS_LATCH_STROBE_N;
  logic CYCLE_QUALIFIER_N, ACCESS_DIRECTION, ASYNC_READY_OUT, SYNC_READY_N, LOCAL_DEVICE_CLAIM_N;
  logic ACC_REQ, ACC_WRITE, aw, low, cl, to;
  logic [ADDR_HI:ADDR_LO] HOST_ADDR, ACC_ADDR, aa;
  logic [LANES-1:0] BYTE_LANE_ENABLE_N, DATA_OE, ACC_BE, abe, oe;
  logic [DATA_W-1:0] DATA_IN, DATA_OUT, ACC_WDATA, wd, q, m;
  logic [DATA_W-1:0] ACC_RDATA = RD_PAT;
  logic [2:0] pipe_q = 3'h0;
  int checked = 0, fail_count = 0, reqs = 0, n0;
  hbp_row_t r;

  always #2.5 MCLK = ~MCLK;

  hbp_top dut (.MCLK, .SYS_RST, .LOCAL_BUS_MODE_SELECT_N, .BUS_CLK, .HOST_ADDR, .IO_SPACE_QUALIFIER,
    .ASYNC_READ_STROBE_N, .ASYNC_WRITE_STROBE_N, .BYTE_LANE_ENABLE_N, .ADDRESS_LATCH_STROBE_N,
    .CYCLE_QUALIFIER_N, .ACCESS_DIRECTION, .DATA_IN, .DATA_OUT, .DATA_OE, .ASYNC_READY_OUT, .SYNC_READY_N,
    .LOCAL_DEVICE_CLAIM_N, .ACC_REQ, .ACC_WRITE, .ACC_ADDR, .ACC_BE, .ACC_WDATA, .ACC_DONE, .ACC_RDATA);
  hbp_host_model host (.MCLK, .BUS_CLK, .HOST_ADDR, .IO_SPACE_QUALIFIER, .ASYNC_READ_STROBE_N,
    .ASYNC_WRITE_STROBE_N, .BYTE_LANE_ENABLE_N, .ADDRESS_LATCH_STROBE_N, .CYCLE_QUALIFIER_N,
    .ACCESS_DIRECTION, .DATA_IN, .DATA_OUT, .DATA_OE, .ASYNC_READY_OUT, .SYNC_READY_N, .LOCAL_DEVICE_CLAIM_N);

  // internal side answers four clocks late, so ready has to stretch
  always @(posedge MCLK) begin
    pipe_q <= {pipe_q[1:0], ACC_REQ === 1'b1};
    ACC_DONE <= pipe_q[2];
    if (ACC_REQ === 1'b1) begin
      reqs++;
      {aw, aa, abe, wd} = {ACC_WRITE, ACC_ADDR, ACC_BE, ACC_WDATA};
    end
  end

  function automatic logic [31:0] lane_mask(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  task automatic end_of_test();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // hang guard well above the longest legal sequence
  initial begin
    repeat (60000) @(posedge MCLK);
    fail_count++;
    end_of_test();
  end

  initial begin
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    `CHK("reset idle", 8'h0E, {DATA_OE, ASYNC_READY_OUT, SYNC_READY_N, LOCAL_DEVICE_CLAIM_N, ACC_REQ})
    repeat (8) @(posedge MCLK);
    for (int i = 0; i < 8; i++) begin
      r = ROWS[i];
      n0 = reqs;
      host.isa(r.wr, r.io, r.a, r.be, WR_PAT, low, cl, q, oe);
      m = lane_mask(r.ln);
      `CHK("ready drop", r.low, low)
      `CHK("claim", r.cl, cl)
      `CHK("requests", 32'(r.req), reqs - n0)
      `CHK("lanes driven", r.wr ? 4'h0 : r.ln, oe)
      if (r.req && !r.wr) `CHK("read data", RD_PAT & m, q & m)
      if (r.req && r.wr) `CHK("write lanes", r.ln, abe)
      if (r.req && r.wr) `CHK("write data", WR_PAT & m, wd & m)
      if (r.req) `CHK("address", r.a, aa)
    end
    // awkward case: ready must come back after it drops, in local mode too
    LOCAL_BUS_MODE_SELECT_N <= 1'b0;
    repeat (8) @(posedge MCLK);
    for (int i = 0; i < 7; i++) begin
      host.lb(1'b0, HIT, LB_BE[i], WR_PAT, q, oe, to);
      `CHK("local ready", 1'b0, to)
      `CHK("local lanes", ~LB_BE[i], oe)
      `CHK("local data", RD_PAT & lane_mask(~LB_BE[i]), q & lane_mask(~LB_BE[i]))
      `CHK("local direction", 1'b0, aw)
    end
    host.lb(1'b1, HIT, BE_HIGH, WR_PAT, q, oe, to);
    `CHK("local write", 1'b1, aw)
    `CHK("latched address", HIT, aa)
    `CHK("latched lanes", 4'hC, abe)
    `CHK("write word", WR_PAT[31:16], wd[31:16])
    n0 = reqs;
    host.lb(1'b0, HIT, 4'hA, WR_PAT, q, oe, to);
    `CHK("odd lanes refused", 1'b1, to)
    `CHK("no request", n0, reqs)
    end_of_test();
  end
endmodule
